/* design/bridge_cfg_pkg.sv */
// package: register map, field layout, reset values, shared types
`default_nettype none
package bridge_cfg_pkg;
  // register byte offsets (8-bit access port)
  localparam logic [7:0] ARB_OFFS = 8'h6e;
  localparam logic [7:0] CLK_OFFS = 8'h6f;
  localparam logic [7:0] DIAG_LO_OFFS = 8'h70;
  localparam logic [7:0] DIAG_HI_OFFS = 8'h71;
  // reset values
  localparam logic [7:0] ARB_RESET = 8'h40;
  localparam logic [7:0] CLK_RESET = 8'h00;
  localparam logic [15:0] DIAG_RESET = 16'h1340;
  // arbitration fields
  localparam int PARK_BIT = 7;
  localparam int BRIDGE_TIER_BIT = 6;
  localparam int NUM_GNT = 6;
  localparam int NUM_REQ = 7;
  localparam logic [2:0] BRIDGE_IDX = 3'h6;
  // clock-stop fields
  localparam int MODE_BIT = 4;
  localparam int PRI_EN_BIT = 3;
  localparam int KEEP_BIT = 2;
  localparam int SEC_EN_BIT = 1;
  localparam int STAT_BIT = 0;
  localparam logic [7:0] CLK_WMASK = 8'h1e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef enum logic [0:0] {
    CLK_RUN = 1'b0,
    CLK_STOP = 1'b1
  } clk_state_e;
endpackage
`default_nettype wire

/* design/tier_rotator.sv */
// rotating one-hot picker among a request vector
`default_nettype none
module tier_rotator (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests and pick
  input wire logic [6:0] req,
  input wire logic advance,
  output logic [6:0] pick
);
  logic [2:0] last_q;
  logic [2:0] last_d;
  logic [13:0] dbl;
  logic [6:0] found;
  logic [2:0] idx;

  always_comb begin
    pick = '0;
    idx = last_q;
    dbl = {req, req};
    found = '0;
    for (int k = 1; k <= 7; k++) begin
      if (found == '0 && dbl[(32'(last_q) + k)] ) begin
        found = 7'h01;
        idx = 3'((32'(last_q) + k) % 7);
      end
    end
    if (found != '0) begin
      pick[idx] = 1'b1;
    end
    last_d = (advance && found != '0) ? idx : last_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      last_q <= bridge_cfg_pkg::BRIDGE_IDX;
    end else begin
      last_q <= last_d;
    end
  end
endmodule
`default_nettype wire

/* design/sync2.sv */
// two-flop synchroniser for pin inputs
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] pin_level,
  output logic [W-1:0] synced
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  // reset to the pin's idle level so no false request follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= IDLE;
      s2_q <= IDLE;
    end else begin
      s1_q <= pin_level;
      s2_q <= s1_q;
    end
  end
  assign synced = s2_q;
endmodule
`default_nettype wire

/* design/bridge_arb_clockrun_config.sv */
// arbiter priority/parking, secondary clock-run control, diagnostic reg
//
// The address-and-strobe port was decided locally.
`default_nettype none
// Operation
// - parking bit set parks bus on bridge
// - parking bit clear parks on last master
// - bit 6 picks bridge priority tier
// - bits 5..0 pick grant line tiers
// - two tiers, rotating within, high first
// - mode 0 stops only on primary request
// - mode 1 stops when idle, nothing pending
// - downstream transaction restarts stopped clock
// - keepalive request restarts stopped clock
// - primary stop requests need enable bit 3
// - keep bit asks primary clock running
// - keep clear allows stop if secondary stopped
// - bit 1 gates all secondary clock stopping
// - status bit 0 shows clock stopped
// - diagnostic register read/write, resets 1340h
module bridge_arb_clockrun_config (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // secondary arbitration
  input wire logic [5:0] secondary_req_n,
  input wire logic bridge_req,
  input wire logic secondary_bus_idle,
  output logic [5:0] secondary_grant_line_n,
  output logic bridge_grant,
  // clock run
  input wire logic primary_stop_request,
  input wire logic primary_pending,
  input wire logic downstream_arrival,
  input wire logic secondary_clock_keepalive_request_n,
  output logic secondary_clock_stop,
  output logic primary_keep_clock,
  output logic primary_stop_permit,
  // diagnostic fields out
  output logic [15:0] diag_ctrl
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int NUM_GNT_W = bridge_cfg_pkg::NUM_GNT;
  // pins are active low; inverted only after the second flop
  logic [5:0] sec_req_n_s;
  logic [5:0] sec_req;
  logic keepalive_n_s;
  logic keepalive_s;

  sync2 #(.W(NUM_GNT_W), .IDLE({NUM_GNT_W{1'b1}})) u_req_sync (
    .clk(clk),
    .rst(rst),
    .pin_level(secondary_req_n),
    .synced(sec_req_n_s)
  );

  sync2 #(.W(1), .IDLE(1'b1)) u_keep_sync (
    .clk(clk),
    .rst(rst),
    .pin_level(secondary_clock_keepalive_request_n),
    .synced(keepalive_n_s)
  );

  assign sec_req = ~sec_req_n_s;
  assign keepalive_s = ~keepalive_n_s;

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  bridge_cfg_pkg::reg_req_s req;
  logic hit_arb;
  logic hit_clk;
  logic hit_diag_lo;
  logic hit_diag_hi;
  bridge_cfg_pkg::clk_state_e cst_q;
  bridge_cfg_pkg::clk_state_e cst_d;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign hit_arb = (req.addr == bridge_cfg_pkg::ARB_OFFS);
  assign hit_clk = (req.addr == bridge_cfg_pkg::CLK_OFFS);
  assign hit_diag_lo = (req.addr == bridge_cfg_pkg::DIAG_LO_OFFS);
  assign hit_diag_hi = (req.addr == bridge_cfg_pkg::DIAG_HI_OFFS);

  // ---------------------------------------------------------------
  // arbitration register
  // ---------------------------------------------------------------
  logic [7:0] arb_q;
  logic [7:0] arb_d;

  always_comb begin
    arb_d = arb_q;
    if (req.wr && hit_arb) begin
      arb_d = req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arb_q <= bridge_cfg_pkg::ARB_RESET;
    end else begin
      arb_q <= arb_d;
    end
  end

  // ---------------------------------------------------------------
  // clock-stop control register
  // ---------------------------------------------------------------
  logic [7:0] clk_q;
  logic [7:0] clk_d;

  always_comb begin
    clk_d = clk_q;
    if (req.wr && hit_clk) begin
      // reserved bits and the status bit never store
      clk_d = req.wdata & bridge_cfg_pkg::CLK_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_q <= bridge_cfg_pkg::CLK_RESET;
    end else begin
      clk_q <= clk_d;
    end
  end

  // ---------------------------------------------------------------
  // diagnostic control register
  // ---------------------------------------------------------------
  logic [15:0] diag_q;
  logic [15:0] diag_d;

  always_comb begin
    diag_d = diag_q;
    if (req.wr && hit_diag_lo) begin
      diag_d[7:0] = req.wdata;
    end
    if (req.wr && hit_diag_hi) begin
      diag_d[15:8] = req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      diag_q <= bridge_cfg_pkg::DIAG_RESET;
    end else begin
      diag_q <= diag_d;
    end
  end

  assign diag_ctrl = diag_q;

  // ---------------------------------------------------------------
  // read data, valid for one cycle after the read strobe
  // ---------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic clk_stopped;

  assign clk_stopped = (cst_q == bridge_cfg_pkg::CLK_STOP);

  always_comb begin
    rdata_d = 8'h00;
    if (req.rd) begin
      case (req.addr)
        bridge_cfg_pkg::ARB_OFFS: rdata_d = arb_q;
        bridge_cfg_pkg::CLK_OFFS: begin
          rdata_d = clk_q & bridge_cfg_pkg::CLK_WMASK;
          rdata_d[bridge_cfg_pkg::STAT_BIT] = clk_stopped;
        end
        bridge_cfg_pkg::DIAG_LO_OFFS: rdata_d = diag_q[7:0];
        bridge_cfg_pkg::DIAG_HI_OFFS: rdata_d = diag_q[15:8];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // secondary arbiter
  // ---------------------------------------------------------------
  logic [6:0] all_req;
  logic [6:0] tier_hi;
  logic [6:0] hi_req;
  logic [6:0] lo_req;
  logic [6:0] hi_pick;
  logic [6:0] lo_pick;
  logic [6:0] gnt_d;
  logic [6:0] gnt_q;
  logic [2:0] last_d;
  logic [2:0] last_q;
  logic use_hi;
  logic use_lo;

  assign all_req = {bridge_req, sec_req};
  assign tier_hi = arb_q[bridge_cfg_pkg::BRIDGE_TIER_BIT:0];
  assign hi_req = all_req & tier_hi;
  assign lo_req = all_req & ~tier_hi;
  assign use_hi = secondary_bus_idle && (hi_req != '0);
  assign use_lo = secondary_bus_idle && (hi_req == '0) && (lo_req != '0);

  tier_rotator u_hi (
    .clk(clk),
    .rst(rst),
    .req(hi_req),
    .advance(use_hi),
    .pick(hi_pick)
  );

  tier_rotator u_lo (
    .clk(clk),
    .rst(rst),
    .req(lo_req),
    .advance(use_lo),
    .pick(lo_pick)
  );

  always_comb begin
    gnt_d = gnt_q;
    last_d = last_q;
    if (secondary_bus_idle) begin
      if (use_hi) begin
        gnt_d = hi_pick;
      end else if (use_lo) begin
        gnt_d = lo_pick;
      end else if (arb_q[bridge_cfg_pkg::PARK_BIT]) begin
        gnt_d = 7'h01 << bridge_cfg_pkg::BRIDGE_IDX;
      end else begin
        gnt_d = 7'h01 << last_q;
      end
    end
    for (int i = 0; i < bridge_cfg_pkg::NUM_REQ; i++) begin
      if (gnt_d[i] && all_req[i]) begin
        last_d = 3'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gnt_q <= 7'h01 << bridge_cfg_pkg::BRIDGE_IDX;
      last_q <= bridge_cfg_pkg::BRIDGE_IDX;
    end else begin
      gnt_q <= gnt_d;
      last_q <= last_d;
    end
  end

  // one active-low grant pin per secondary line
  for (genvar g = 0; g < bridge_cfg_pkg::NUM_GNT; g++) begin : g_line
    assign secondary_grant_line_n[g] = ~gnt_q[g];
  end
  assign bridge_grant = gnt_q[bridge_cfg_pkg::BRIDGE_IDX];

  // ---------------------------------------------------------------
  // secondary clock-run control
  // ---------------------------------------------------------------
  logic stop_ok;
  logic restart;

  always_comb begin
    restart = downstream_arrival || keepalive_s;
    if (clk_q[bridge_cfg_pkg::MODE_BIT]) begin
      stop_ok = secondary_bus_idle && !primary_pending;
    end else begin
      stop_ok = primary_stop_request &&
        clk_q[bridge_cfg_pkg::PRI_EN_BIT];
    end
    cst_d = cst_q;
    case (cst_q)
      bridge_cfg_pkg::CLK_RUN: begin
        if (clk_q[bridge_cfg_pkg::SEC_EN_BIT] && stop_ok && !restart) begin
          cst_d = bridge_cfg_pkg::CLK_STOP;
        end
      end
      bridge_cfg_pkg::CLK_STOP: begin
        if (restart || !clk_q[bridge_cfg_pkg::SEC_EN_BIT]) begin
          cst_d = bridge_cfg_pkg::CLK_RUN;
        end
      end
      default: cst_d = bridge_cfg_pkg::CLK_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cst_q <= bridge_cfg_pkg::CLK_RUN;
    end else begin
      cst_q <= cst_d;
    end
  end

  assign secondary_clock_stop = (cst_q == bridge_cfg_pkg::CLK_STOP);
  assign primary_keep_clock = clk_q[bridge_cfg_pkg::KEEP_BIT];
  assign primary_stop_permit = !clk_q[bridge_cfg_pkg::KEEP_BIT] &&
    (cst_q == bridge_cfg_pkg::CLK_STOP);
endmodule
`default_nettype wire

/* dv/sec_masters.sv */
// partner: secondary bus masters and keepalive requester
`default_nettype none
module sec_masters (
  // clock
  input wire logic clk,
  // commands from the bench
  input wire logic [5:0] want,
  input wire logic keep,
  // pins toward the bridge
  output var logic [5:0] req_n = 6'h3f,
  output var logic keepalive_n = 1'h1
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk) begin
    req_n <= ~want;
    keepalive_n <= ~keep;
  end
endmodule
`default_nettype wire

/* dv/bridge_cfg_assertions.sv */
// checker: port-level properties of the config block
`default_nettype none
module bridge_cfg_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic secondary_bus_idle,
  input wire logic [5:0] secondary_grant_line_n,
  input wire logic bridge_grant,
  input wire logic downstream_arrival,
  input wire logic secondary_clock_keepalive_request_n,
  input wire logic secondary_clock_stop,
  input wire logic primary_keep_clock,
  input wire logic primary_stop_permit,
  input wire logic [15:0] diag_ctrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_one_grant: assert property (
    $onehot({bridge_grant, ~secondary_grant_line_n}))
    else $error("grant not one-hot");
  chk_grant_hold: assert property (
    !secondary_bus_idle |=> $stable(secondary_grant_line_n)
    && $stable(bridge_grant))
    else $error("grant moved on busy bus");
  chk_rdata_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_stop_permit: assert property (
    primary_stop_permit == (!primary_keep_clock && secondary_clock_stop))
    else $error("stop permit wrong");
  chk_down_restart: assert property (
    secondary_clock_stop && downstream_arrival |=> !secondary_clock_stop)
    else $error("no restart on downstream");
  chk_keep_restart: assert property (
    !secondary_clock_keepalive_request_n [*5] |-> !secondary_clock_stop)
    else $error("no restart on keepalive");
  chk_diag_write: assert property (
    reg_wr && reg_addr == 8'h70 |=> diag_ctrl[7:0] == $past(reg_wdata))
    else $error("diag low byte not written");
  chk_status_read: assert property (
    reg_rd && reg_addr == 8'h6f |=> reg_rdata[0] == $past(secondary_clock_stop)
    && reg_rdata[7:5] == 3'h0)
    else $error("clock status read wrong");
endmodule
bind bridge_arb_clockrun_config bridge_cfg_checker chk (.clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .secondary_bus_idle,
  .secondary_grant_line_n, .bridge_grant, .downstream_arrival,
  .secondary_clock_keepalive_request_n, .secondary_clock_stop,
  .primary_keep_clock, .primary_stop_permit, .diag_ctrl);
`default_nettype wire

/* dv/tb_top.sv */
// testbench: register, clock-stop and arbiter scenarios
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, wr = 0, rd = 0, breq = 0, idle = 1;
  logic stop_req = 0, pend = 0, dn = 0, keep = 0;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [5:0] want = 0, req_n, gnt_n;
  logic ka_n, sstop, kclk, permit, bgnt;
  logic [15:0] diag;
  int bad_count = 0, n_tests = 0, cycles = 0;
  bridge_arb_clockrun_config dut (.clk, .rst, .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .secondary_req_n(req_n), .bridge_req(breq),
    .secondary_bus_idle(idle), .secondary_grant_line_n(gnt_n),
    .bridge_grant(bgnt), .primary_stop_request(stop_req),
    .primary_pending(pend), .downstream_arrival(dn),
    .secondary_clock_keepalive_request_n(ka_n),
    .secondary_clock_stop(sstop), .primary_keep_clock(kclk),
    .primary_stop_permit(permit), .diag_ctrl(diag));
  sec_masters partner (.clk, .want, .keep, .req_n, .keepalive_n(ka_n));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1;
    chk("reg_rdata", {8'h00, exp}, {8'h00, rdata});
  endtask
  // settle, then judge clock outputs; leaves caller on an edge
  task automatic stopped(logic exp, logic kp);
    repeat (6) @(posedge clk);
    #1;
    chk("clock_stop", {15'h0, exp}, {15'h0, sstop});
    chk("keep_clock", {15'h0, kp}, {15'h0, kclk});
    chk("stop_permit", {15'h0, exp & !kp}, {15'h0, permit});
    @(posedge clk);
  endtask
  task automatic gnt(logic [6:0] exp);
    repeat (6) @(posedge clk);
    #1;
    chk("grants", {9'h0, exp}, {9'h0, bgnt, ~gnt_n});
    @(posedge clk);
  endtask
  task automatic t_reset;
    #1;
    chk("diag_ctrl", 16'h1340, diag);
    rreg(8'h6e, 8'h40);
    rreg(8'h6f, 8'h00);
    rreg(8'h71, 8'h13);
    rreg(8'h55, 8'h00);
  endtask
  task automatic t_regs;
    wreg(8'h6f, 8'hfc);
    rreg(8'h6f, 8'h1c);
    wreg(8'h70, 8'ha5);
    wreg(8'h71, 8'h5a);
    rreg(8'h70, 8'ha5);
    chk("diag_ctrl", 16'h5aa5, diag);
    wreg(8'h55, 8'h77);
    rreg(8'h55, 8'h00);
    wreg(8'h6f, 8'h00);
  endtask
  task automatic t_mode0;
    wreg(8'h6f, 8'h0a);
    stopped(0, 0);
    stop_req <= 1;
    stopped(1, 0);
    rreg(8'h6f, 8'h0b);
    dn <= 1;
    stopped(0, 0);
    dn <= 0;
    stop_req <= 0;
    wreg(8'h6f, 8'h02);
    stop_req <= 1;
    stopped(0, 0);
    stop_req <= 0;
  endtask
  task automatic t_mode1;
    pend <= 1;
    wreg(8'h6f, 8'h12);
    stopped(0, 0);
    pend <= 0;
    stopped(1, 0);
    keep <= 1;
    stopped(0, 0);
    keep <= 0;
    wreg(8'h6f, 8'h16);
    stopped(1, 1);
    wreg(8'h6f, 8'h14);
    stopped(0, 1);
    wreg(8'h6f, 8'h00);
  endtask
  task automatic t_arb;
    wreg(8'h6e, 8'h80);
    want <= 6'h01;
    gnt(7'h01);
    want <= 6'h00;
    gnt(7'h40);
    wreg(8'h6e, 8'h00);
    want <= 6'h04;
    gnt(7'h04);
    want <= 6'h00;
    gnt(7'h04);
    idle <= 0;
    want <= 6'h01;
    gnt(7'h04);
    idle <= 1;
    gnt(7'h01);
    wreg(8'h6e, 8'h08);
    want <= 6'h0a;
    breq <= 1;
    gnt(7'h08);
    wreg(8'h6e, 8'h40);
    gnt(7'h40);
    breq <= 0;
    want <= 6'h00;
  endtask
  // two same-tier masters asking together must both be served
  task automatic t_rotate;
    logic [6:0] g1;
    logic [6:0] g2;
    wreg(8'h6e, 8'h00);
    want <= 6'h0a;
    repeat (6) @(posedge clk);
    #1;
    g1 = {bgnt, ~gnt_n};
    @(posedge clk);
    #1;
    g2 = {bgnt, ~gnt_n};
    chk("rotation", 16'h000a, {9'h0, g1 | g2});
    @(posedge clk);
    want <= 6'h00;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_reset();
    t_regs();
    t_mode0();
    t_mode1();
    t_arb();
    t_rotate();
    conclude();
  end
endmodule
`default_nettype wire
